// file: hw/counter_array_pkg.sv
// Package for the counter array block: register indices, field positions, codes and carriers.
// Assumes a single 40 MHz oscillator clock; byte address on the bus is four times the index.
package counter_array_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_CLOCK_DIVIDER_SELECT = 8'h8f;
	localparam logic [7:0] IDX_PORT_OUT = 8'h90;
	localparam logic [7:0] IDX_PORT_DIR = 8'h91;
	localparam logic [7:0] IDX_PIN_READ = 8'h92;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hd7;
	localparam logic [7:0] IDX_COUNTER_CONTROL = 8'hd8;
	localparam logic [7:0] IDX_COUNTER_MODE = 8'hd9;
	localparam logic [7:0] IDX_MODULE_MODE_BASE = 8'hda;
	localparam logic [7:0] IDX_COUNT_LO = 8'he9;
	localparam logic [7:0] IDX_COMPARE_LO_BASE = 8'hea;
	localparam logic [7:0] IDX_COUNT_HI = 8'hf9;
	localparam logic [7:0] IDX_COMPARE_HI_BASE = 8'hfa;
	// Field positions.
	localparam int DOUBLING_BIT = 0;
	localparam int HALVING_BIT = 5;
	localparam int OVF_IRQ_ENABLE_BIT = 0;
	localparam int SOURCE_SEL_LO_BIT = 1;
	localparam int SOURCE_SEL_HI_BIT = 2;
	localparam int WATCHDOG_ENABLE_BIT = 6;
	localparam int RUN_BIT = 6;
	localparam int OVERFLOW_FLAG_BIT = 7;
	localparam logic [7:0] CONTROL_FLAG_MASK = 8'h9f;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Counter sizes and figures.
	localparam int NUM_MODULES = 5;
	localparam int NUM_PINS = 6;
	localparam int COUNT_PIN = 0;
	localparam logic [2:0] PHASES_PER_CYCLE = 3'h6;
	localparam logic [2:0] PRESCALE_DIV6 = 3'h6;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [7:0] PWM_WRAP = 8'hff;
	// Counter source codes.
	typedef enum logic [1:0] {
		SRC_DIV6 = 2'h0,
		SRC_DIV2 = 2'h1,
		SRC_TIMER0 = 2'h2,
		SRC_EXTERNAL = 2'h3
	} count_source_e;
	// Bus handshake states.
	typedef enum logic [1:0] {
		BUS_IDLE = 2'h0,
		BUS_ACK = 2'h1
	} bus_state_e;
	// Module mode register layout.
	typedef struct packed {
		logic reserved;
		logic comparator_enable;
		logic capture_rising;
		logic capture_falling;
		logic flag_on_match;
		logic toggle_on_match;
		logic pwm_enable;
		logic event_irq_enable;
	} module_mode_s;
	// Two-way pin bundle; output enable is active low.
	typedef struct packed {
		logic [NUM_PINS-1:0] value;
		logic [NUM_PINS-1:0] drive_n;
	} pin_drive_s;
endpackage : counter_array_pkg

// file: hw/counter_array_capture_compare.sv
// Counter array with one 16-bit time base and five compare/capture modules behind an Avalon-MM slave.
// Assumes sys_clk_in is the oscillator input; pins arrive asynchronously and the
// timer 0 overflow pulse comes from logic on the same clock.
`timescale 1ns/100ps

// Operation
// - Counter source: div6, div2, timer0, external pin.
// - One 16-bit counter shared by all modules.
// - Capture edges, software timer, fast output, PWM.
// - Mode bits 4/5 pick falling/rising capture.
// - Mode bit 0 lets event flag interrupt.
// - Mode bit 1 selects 8-bit PWM output.
// - Mode bit 2 toggles pin on match.
// - Mode bit 3 sets flag on match.
// - Mode bit 6 enables comparator functions.
// - Capture, timer, output modes can interrupt.
// - Module and overflow requests share one interrupt.
// - Module 4 may act as watchdog.
// - Unused pins stay general-purpose I/O.
// - Halving bit picks 6 or 12 under doubling.
// - Default divide-by-2 stage, software can bypass.
// - Doubling gives 6 periods per machine cycle.
// - Doubling change applies on divided-clock rising edge.
module counter_array_capture_compare
	import counter_array_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic [9:0] address_in,
	input wire logic [3:0] byteenable_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [31:0] writedata_in,
	output logic [31:0] readdata_out,
	output logic waitrequest_out,
	input wire logic timer0_overflow_in,
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic [NUM_PINS-1:0] pin_out,
	output logic [NUM_PINS-1:0] pin_oe_n_out,
	output logic irq_out,
	output logic watchdog_reset_out,
	output logic machine_cycle_out
);

	// True when the word address selects the given register index.
	function automatic logic idx_hit(input logic [9:0] addr, input logic [7:0] idx);
		idx_hit = (addr[9:2] == idx);
	endfunction : idx_hit

	bus_state_e bus_q;
	logic [31:0] rd_q;
	logic [31:0] rd_d;
	logic wr_go;
	logic [7:0] wbyte;
	logic [7:0] clkdiv_q;
	logic [7:0] cmode_q;
	logic [7:0] cctrl_q;
	logic [7:0] mask_q;
	logic [NUM_PINS-1:0] port_out_q;
	logic [NUM_PINS-1:0] port_dir_q;
	module_mode_s mode_q [NUM_MODULES];
	logic [15:0] cmp_q [NUM_MODULES];
	logic [7:0] duty_q [NUM_MODULES];
	logic [NUM_MODULES-1:0] tog_q;
	logic [15:0] cnt_q;
	logic moved_q;
	logic half_q;
	logic x2_eff_q;
	logic [2:0] mphase_q;
	logic [2:0] pphase_q;
	logic [2:0] pre_q;
	logic phase_tick;
	logic periph_phase;
	logic periph_tick;
	logic count_tick;
	logic [NUM_PINS-1:0] sync1_q;
	logic [NUM_PINS-1:0] sync2_q;
	logic [NUM_PINS-1:0] prev_q;
	logic [NUM_MODULES-1:0] match;
	logic [NUM_MODULES-1:0] capture;
	logic overflow;
	pin_drive_s drive_d;
	pin_drive_s drive_q;
	logic irq_q;
	logic wdt_q;
	logic mtick_q;

	// Bus handshake: waitrequest drops for exactly one cycle after a request is seen.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			bus_q <= BUS_IDLE;
		end else if (bus_q == BUS_IDLE && (read_in || write_in)) begin
			bus_q <= BUS_ACK;
		end else begin
			bus_q <= BUS_IDLE;
		end
	end

	// A write lands at the edge where the master samples waitrequest low.
	assign wr_go = write_in && (bus_q == BUS_ACK) && byteenable_in[0];
	assign wbyte = writedata_in[7:0];

	// Read data is captured while waiting so it stands at the completing edge.
	always_comb begin
		rd_d = 32'h0000_0000;
		if (idx_hit(address_in, IDX_CLOCK_DIVIDER_SELECT)) begin
			rd_d[7:0] = clkdiv_q;
		end
		if (idx_hit(address_in, IDX_COUNTER_MODE)) begin
			rd_d[7:0] = cmode_q;
		end
		if (idx_hit(address_in, IDX_COUNTER_CONTROL)) begin
			rd_d[7:0] = cctrl_q;
		end
		if (idx_hit(address_in, IDX_IRQ_MASK)) begin
			rd_d[7:0] = mask_q;
		end
		if (idx_hit(address_in, IDX_COUNT_LO)) begin
			rd_d[7:0] = cnt_q[7:0];
		end
		if (idx_hit(address_in, IDX_COUNT_HI)) begin
			rd_d[7:0] = cnt_q[15:8];
		end
		if (idx_hit(address_in, IDX_PORT_OUT)) begin
			rd_d[NUM_PINS-1:0] = port_out_q;
		end
		if (idx_hit(address_in, IDX_PORT_DIR)) begin
			rd_d[NUM_PINS-1:0] = port_dir_q;
		end
		if (idx_hit(address_in, IDX_PIN_READ)) begin
			rd_d[NUM_PINS-1:0] = sync2_q;
		end
		for (int n = 0; n < NUM_MODULES; n++) begin
			if (idx_hit(address_in, IDX_MODULE_MODE_BASE + 8'(n))) begin
				rd_d[7:0] = mode_q[n];
			end
			if (idx_hit(address_in, IDX_COMPARE_LO_BASE + 8'(n))) begin
				rd_d[7:0] = cmp_q[n][7:0];
			end
			if (idx_hit(address_in, IDX_COMPARE_HI_BASE + 8'(n))) begin
				rd_d[7:0] = cmp_q[n][15:8];
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			rd_q <= 32'h0000_0000;
		end else if (bus_q == BUS_IDLE && read_in) begin
			rd_q <= rd_d;
		end
	end

	// Plain configuration registers written by software.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			clkdiv_q <= REG_RESET;
			cmode_q <= REG_RESET;
			mask_q <= REG_RESET;
			port_out_q <= '0;
			port_dir_q <= '0;
		end else if (wr_go) begin
			if (idx_hit(address_in, IDX_CLOCK_DIVIDER_SELECT)) begin
				clkdiv_q <= wbyte;
			end
			if (idx_hit(address_in, IDX_COUNTER_MODE)) begin
				cmode_q <= wbyte;
			end
			if (idx_hit(address_in, IDX_IRQ_MASK)) begin
				mask_q <= wbyte;
			end
			if (idx_hit(address_in, IDX_PORT_OUT)) begin
				port_out_q <= wbyte[NUM_PINS-1:0];
			end
			if (idx_hit(address_in, IDX_PORT_DIR)) begin
				port_dir_q <= wbyte[NUM_PINS-1:0];
			end
		end
	end

	// Divide-by-2 stage; its rising edge is the only moment the doubling choice may change,
	// so a mode switch never shortens a phase into a glitch.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			half_q <= 1'b0;
			x2_eff_q <= 1'b0;
		end else begin
			half_q <= ~half_q;
			if (!half_q) begin
				x2_eff_q <= clkdiv_q[DOUBLING_BIT];
			end
		end
	end

	// With doubling every oscillator edge is a phase, otherwise only every second one.
	assign phase_tick = x2_eff_q | half_q;
	// The halving bit only matters while doubling is on.
	assign periph_phase = (x2_eff_q && clkdiv_q[HALVING_BIT]) ? half_q : phase_tick;

	// Machine cycle and peripheral cycle counters, six phases each.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			mphase_q <= 3'h0;
			pphase_q <= 3'h0;
			mtick_q <= 1'b0;
		end else begin
			mtick_q <= 1'b0;
			if (phase_tick) begin
				if (mphase_q == PHASES_PER_CYCLE - 3'h1) begin
					mphase_q <= 3'h0;
					mtick_q <= 1'b1;
				end else begin
					mphase_q <= mphase_q + 3'h1;
				end
			end
			if (periph_phase) begin
				pphase_q <= (pphase_q == PHASES_PER_CYCLE - 3'h1) ? 3'h0 : pphase_q + 3'h1;
			end
		end
	end

	assign periph_tick = periph_phase && (pphase_q == PHASES_PER_CYCLE - 3'h1);

	// Prescaler shared by the divide-by-6 and divide-by-2 sources.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			pre_q <= 3'h0;
		end else if (periph_tick) begin
			pre_q <= (pre_q == PRESCALE_DIV6 - 3'h1) ? 3'h0 : pre_q + 3'h1;
		end
	end

	// Pin synchroniser; only the second stage and its delayed copy are ever examined.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// Count source selection; the external pin counts on falling transitions.
	always_comb begin
		unique case (count_source_e'(cmode_q[SOURCE_SEL_HI_BIT:SOURCE_SEL_LO_BIT]))
			SRC_DIV6: count_tick = periph_tick && (pre_q == PRESCALE_DIV6 - 3'h1);
			SRC_DIV2: count_tick = periph_tick && pre_q[0];
			SRC_TIMER0: count_tick = timer0_overflow_in;
			SRC_EXTERNAL: count_tick = prev_q[COUNT_PIN] && !sync2_q[COUNT_PIN];
		endcase
	end

	assign overflow = count_tick && cctrl_q[RUN_BIT] && (cnt_q == COUNT_MAX);

	// Shared time base; software may load either byte, and a load wins over a count.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			cnt_q <= 16'h0000;
			moved_q <= 1'b0;
		end else begin
			moved_q <= count_tick && cctrl_q[RUN_BIT];
			if (count_tick && cctrl_q[RUN_BIT]) begin
				cnt_q <= cnt_q + 16'h0001;
			end
			if (wr_go && idx_hit(address_in, IDX_COUNT_LO)) begin
				cnt_q[7:0] <= wbyte;
			end
			if (wr_go && idx_hit(address_in, IDX_COUNT_HI)) begin
				cnt_q[15:8] <= wbyte;
			end
		end
	end

	// Match and capture events per module; a match is judged once after each count step.
	always_comb begin
		for (int n = 0; n < NUM_MODULES; n++) begin
			match[n] = mode_q[n].comparator_enable && moved_q && (cnt_q == cmp_q[n]);
			capture[n] = (mode_q[n].capture_rising && sync2_q[n+1] && !prev_q[n+1])
				|| (mode_q[n].capture_falling && !sync2_q[n+1] && prev_q[n+1]);
		end
	end

	// Module registers; a capture overrides a software write in the same cycle.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			for (int n = 0; n < NUM_MODULES; n++) begin
				mode_q[n] <= module_mode_s'(REG_RESET);
				cmp_q[n] <= 16'h0000;
			end
		end else begin
			for (int n = 0; n < NUM_MODULES; n++) begin
				if (wr_go && idx_hit(address_in, IDX_MODULE_MODE_BASE + 8'(n))) begin
					mode_q[n] <= module_mode_s'(wbyte);
				end
				if (wr_go && idx_hit(address_in, IDX_COMPARE_LO_BASE + 8'(n))) begin
					cmp_q[n][7:0] <= wbyte;
				end
				if (wr_go && idx_hit(address_in, IDX_COMPARE_HI_BASE + 8'(n))) begin
					cmp_q[n][15:8] <= wbyte;
				end
				if (capture[n]) begin
					cmp_q[n] <= cnt_q;
				end
			end
		end
	end

	// High-speed output toggles on a match, and PWM duty reloads at each wrap of the low byte,
	// so a new duty never cuts a period short.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			tog_q <= '0;
			for (int n = 0; n < NUM_MODULES; n++) begin
				duty_q[n] <= 8'h00;
			end
		end else begin
			for (int n = 0; n < NUM_MODULES; n++) begin
				if (match[n] && mode_q[n].toggle_on_match) begin
					tog_q[n] <= ~tog_q[n];
				end
				if (moved_q && cnt_q[7:0] == PWM_WRAP) begin
					duty_q[n] <= cmp_q[n][15:8];
				end
			end
		end
	end

	// Counter control: run bit is plain, flags clear on a written one and a new event wins.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			cctrl_q <= REG_RESET;
		end else begin
			if (wr_go && idx_hit(address_in, IDX_COUNTER_CONTROL)) begin
				cctrl_q <= (cctrl_q & ~(wbyte & CONTROL_FLAG_MASK) & CONTROL_FLAG_MASK)
					| (wbyte & ~CONTROL_FLAG_MASK);
			end
			for (int n = 0; n < NUM_MODULES; n++) begin
				if ((match[n] && mode_q[n].flag_on_match) || capture[n]) begin
					cctrl_q[n] <= 1'b1;
				end
			end
			if (overflow) begin
				cctrl_q[OVERFLOW_FLAG_BIT] <= 1'b1;
			end
		end
	end

	// One shared request from five module flags and the overflow flag, each behind its mask.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= 1'b0;
			for (int n = 0; n < NUM_MODULES; n++) begin
				if (cctrl_q[n] && mode_q[n].event_irq_enable && mask_q[n]) begin
					irq_q <= 1'b1;
				end
			end
			if (cctrl_q[OVERFLOW_FLAG_BIT] && cmode_q[OVF_IRQ_ENABLE_BIT] && mask_q[OVERFLOW_FLAG_BIT]) begin
				irq_q <= 1'b1;
			end
		end
	end

	// Module 4 matching with the watchdog enabled fires a one-cycle reset pulse.
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			wdt_q <= 1'b0;
		end else begin
			wdt_q <= match[NUM_MODULES-1] && cmode_q[WATCHDOG_ENABLE_BIT];
		end
	end

	// Pin drive: a module drives its pin in an output function and releases it in capture, the external source releases pin 0; all else is ordinary I/O.
	always_comb begin
		drive_d.value = port_out_q;
		drive_d.drive_n = ~port_dir_q;
		if (cmode_q[SOURCE_SEL_HI_BIT:SOURCE_SEL_LO_BIT] == SRC_EXTERNAL) begin
			drive_d.drive_n[COUNT_PIN] = 1'b1;
		end
		for (int n = 0; n < NUM_MODULES; n++) begin
			if (mode_q[n].comparator_enable && mode_q[n].pwm_enable) begin
				drive_d.value[n+1] = (cnt_q[7:0] >= duty_q[n]);
				drive_d.drive_n[n+1] = 1'b0;
			end else if (mode_q[n].comparator_enable && mode_q[n].toggle_on_match) begin
				drive_d.value[n+1] = tog_q[n];
				drive_d.drive_n[n+1] = 1'b0;
			end else if (mode_q[n].capture_rising || mode_q[n].capture_falling) begin
				drive_d.drive_n[n+1] = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			drive_q.value <= '0;
			drive_q.drive_n <= '1;
		end else begin
			drive_q <= drive_d;
		end
	end

	// Every output except waitrequest leaves straight from a flip-flop; waitrequest is decoded from bus_q.
	assign readdata_out = rd_q;
	assign waitrequest_out = (bus_q != BUS_ACK);
	assign pin_out = drive_q.value;
	assign pin_oe_n_out = drive_q.drive_n;
	assign irq_out = irq_q;
	assign watchdog_reset_out = wdt_q;
	assign machine_cycle_out = mtick_q;

endmodule : counter_array_capture_compare

// file: tb/counter_array_monitor.sv
// Checker on the counter array ports.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module counter_array_monitor
	import counter_array_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [31:0] readdata_out,
	input wire logic waitrequest_out,
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe_n_out,
	input wire logic irq_out,
	input wire logic watchdog_reset_out,
	input wire logic machine_cycle_out
);
	// A register write lands at the edge where it is acknowledged.
	logic wr_done;
	assign wr_done = write_in && !waitrequest_out;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	// Each request sees one wait state, and the answer lasts one cycle.
	bus_take_a: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
		else $error("bus answer late");
	bus_ack_a: assert property (!waitrequest_out |=> waitrequest_out)
		else $error("bus answer too long");
	// Read data moves only when a read is taken, so a captured value stays readable.
	read_hold_a: assert property (!(read_in && waitrequest_out) |=> $stable(readdata_out))
		else $error("read data moved");
	// Six phases of one or two clocks each make a machine cycle.
	cycle_min_a: assert property (machine_cycle_out |=> !machine_cycle_out [*5])
		else $error("machine cycle short");
	cycle_max_a: assert property (machine_cycle_out |-> ##[6:12] machine_cycle_out)
		else $error("machine cycle long");
	watchdog_pulse_a: assert property (watchdog_reset_out |=> !watchdog_reset_out)
		else $error("watchdog pulse long");
	// Flags clear, and masks and directions change, only by software, so these follow a write.
	irq_drop_a: assert property ($fell(irq_out) && !$past(reset_in) |-> $past(wr_done) || $past(wr_done, 2))
		else $error("interrupt fell with no write");
	pin_dir_a: assert property ($changed(pin_oe_n_out) && !$past(reset_in) |-> $past(wr_done) || $past(wr_done, 2))
		else $error("pin direction moved with no write");
	cover property ($rose(irq_out));
	cover property (watchdog_reset_out);
	cover property ($changed(pin_out));
endmodule : counter_array_monitor

// file: tb/pin_partner.sv
// Board model of the port pins: an outside source on each line.
// Assumes the bench sets the outside levels just after a clock edge.
`timescale 1ns/100ps
module pin_partner
	import counter_array_pkg::*;
(
	input wire logic [NUM_PINS-1:0] pin_out_in,
	input wire logic [NUM_PINS-1:0] pin_oe_n_in,
	input wire logic [NUM_PINS-1:0] ext_in,
	output logic [NUM_PINS-1:0] level_out
);
	// The block's own drive wins; a released line shows the outside source.
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			level_out[i] = pin_oe_n_in[i] ? ext_in[i] : pin_out_in[i];
		end
	end
endmodule : pin_partner

// file: tb/tb_top.sv
// Bench for the counter array: registers, clocking, capture, match, PWM and port pins.
// Assumes the package, the design, the pin model and the checker are compiled first.
`timescale 1ns/100ps
module tb_top;
	import counter_array_pkg::*;
	logic sys_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [9:0] address_in = '0;
	logic [3:0] byteenable_in = 4'hf;
	logic read_in = 1'b0;
	logic write_in = 1'b0;
	logic [31:0] writedata_in = '0;
	logic timer0_overflow_in = 1'b0;
	logic [NUM_PINS-1:0] ext = '1;
	logic [NUM_PINS-1:0] pin_in;
	logic [NUM_PINS-1:0] pin_out;
	logic [NUM_PINS-1:0] pin_oe_n_out;
	logic [31:0] readdata_out;
	logic waitrequest_out;
	logic irq_out;
	logic watchdog_reset_out;
	logic machine_cycle_out;
	logic wd_seen = 1'b0;
	logic wd_clear = 1'b0;
	logic [7:0] rd;
	int fails = 0;
	int comparisons = 0;
	counter_array_capture_compare counter_array_capture_compare_inst (.*);
	pin_partner pin_partner_inst (.pin_out_in(pin_out), .pin_oe_n_in(pin_oe_n_out), .ext_in(ext), .level_out(pin_in));
	// Free-running 40 MHz clock.
	initial forever #12.5 sys_clk_in = ~sys_clk_in;
	// The pulse lasts one cycle, so it is latched for a later look.
	// One process owns the latch; the stimulus only asks for a clear.
	always @(posedge sys_clk_in) begin
		if (wd_clear) begin
			wd_seen <= 1'b0;
		end else if (watchdog_reset_out === 1'b1) begin
			wd_seen <= 1'b1;
		end
	end
	task automatic summarize();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic idle(input int k);
		repeat (k) @(posedge sys_clk_in);
	endtask : idle
	// One bus transfer; entered just after an edge, held until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		address_in <= {idx, 2'b00};
		writedata_in <= {24'h0, wd};
		write_in <= wr;
		read_in <= !wr;
		do begin
			idle(1);
			n++;
		end while (waitrequest_out !== 1'b0 && n < 20);
		rd = readdata_out[7:0];
		write_in <= 1'b0;
		read_in <= 1'b0;
		if (waitrequest_out !== 1'b0) begin
			fails++;
			summarize();
		end
		idle(1);
	endtask : bus
	task automatic tick(input int k);
		repeat (k) begin
			timer0_overflow_in <= 1'b1;
			idle(1);
			timer0_overflow_in <= 1'b0;
			idle(1);
		end
	endtask : tick
	// Clocks from one machine-cycle pulse to the next, bounded.
	task automatic gap(output int g);
		int n;
		n = 0;
		while (machine_cycle_out !== 1'b1 && n < 30) begin
			idle(1);
			n++;
		end
		g = 0;
		do begin
			idle(1);
			g++;
		end while (machine_cycle_out !== 1'b1 && g < 30);
	endtask : gap
	initial begin
		int g;
		logic [15:0] v;
		logic [15:0] w;
		logic [7:0] m;
		logic [7:0] cfg [3] = '{8'h01, 8'h21, 8'h20};
		int per [3] = '{40, 20, 20};
		void'($urandom(32'h4816));
		idle(6);
		reset_in <= 1'b0;
		idle(1);
		// Reset value, a random round trip and an unmapped place.
		bus(0, IDX_CLOCK_DIVIDER_SELECT, 0);
		check(rd, REG_RESET, "divider reset");
		v = 16'($urandom);
		bus(1, IDX_CLOCK_DIVIDER_SELECT, v[7:0]);
		bus(0, IDX_CLOCK_DIVIDER_SELECT, 0);
		check(rd, v[7:0], "divider rw");
		bus(1, 8'h20, 8'h5a);
		bus(0, 8'h20, 0);
		check(rd, 0, "unmapped");
		$display("test registers done");
		// Machine cycle of 12 clocks, then 6 with the divider bypassed.
		for (int d = 0; d < 2; d++) begin
			bus(1, IDX_CLOCK_DIVIDER_SELECT, 8'(d));
			gap(g);
			gap(g);
			check(16'(g), d ? 16'd6 : 16'd12, "machine cycle");
		end
		$display("test clocking done");
		// Divide-by-2 source; a phase offset of one step either way is allowed.
		bus(1, IDX_COUNTER_MODE, 8'h02);
		for (int i = 0; i < 3; i++) begin
			bus(1, IDX_CLOCK_DIVIDER_SELECT, cfg[i]);
			bus(1, IDX_COUNT_LO, 0);
			bus(1, IDX_COUNTER_CONTROL, 8'h40);
			idle(480);
			bus(1, IDX_COUNTER_CONTROL, 0);
			bus(0, IDX_COUNT_LO, 0);
			check(16'(rd + 1 >= per[i] && rd <= per[i] + 1), 1, "count rate");
		end
		$display("test rate done");
		// Each edge selection; timer 0 steps the count from a random start.
		bus(1, IDX_COUNTER_MODE, 8'h04);
		bus(1, IDX_COUNTER_CONTROL, 8'h40);
		for (int e = 1; e < 4; e++) begin
			m = 8'(e << 4);
			bus(1, IDX_MODULE_MODE_BASE, m | 8'h01);
			bus(1, IDX_IRQ_MASK, 8'(e != 2));
			for (int s = 0; s < 2; s++) begin
				v = 16'($urandom);
				bus(1, IDX_COUNT_LO, v[7:0]);
				bus(1, IDX_COUNT_HI, v[15:8]);
				bus(1, IDX_COMPARE_LO_BASE, 0);
				bus(1, IDX_COMPARE_HI_BASE, 0);
				tick(3);
				ext[1] <= s[0];
				idle(8);
				bus(0, IDX_COUNTER_CONTROL, 0);
				check(16'(rd[0]), 16'(m[4 + s]), "capture flag");
				check(16'(irq_out), 16'(m[4 + s] && e != 2), "capture irq");
				bus(0, IDX_COMPARE_LO_BASE, 0);
				w[7:0] = rd;
				bus(0, IDX_COMPARE_HI_BASE, 0);
				w[15:8] = rd;
				check(w, m[4 + s] ? v + 16'd3 : 16'h0, "capture value");
				bus(1, IDX_COUNTER_CONTROL, 8'h41);
			end
		end
		$display("test capture done");
		// Module 4 match with the comparator off, then on.
		bus(1, IDX_COUNTER_MODE, 8'h44);
		for (int c = 0; c < 2; c++) begin
			bus(1, IDX_MODULE_MODE_BASE + 8'd4, c ? 8'h4c : 8'h0c);
			bus(1, IDX_COUNT_LO, 8'h10);
			bus(1, IDX_COUNT_HI, 0);
			bus(1, IDX_COMPARE_LO_BASE + 8'd4, 8'h13);
			bus(1, IDX_COMPARE_HI_BASE + 8'd4, 0);
			wd_clear <= 1'b1;
			idle(1);
			wd_clear <= 1'b0;
			tick(3);
			idle(4);
			bus(0, IDX_COUNTER_CONTROL, 0);
			check(16'(rd[4]), 16'(c), "match flag");
			check(16'(wd_seen), 16'(c), "watchdog");
			check(16'(pin_out[5]), 16'(c), "toggle pin");
			check(16'(pin_oe_n_out[5]), 16'(!c), "toggle drive");
		end
		$display("test match done");
		// PWM on module 1: low one step below the duty, high at it.
		v = 16'($urandom_range(200, 2));
		bus(1, IDX_MODULE_MODE_BASE + 8'd1, 8'h42);
		bus(1, IDX_COMPARE_HI_BASE + 8'd1, v[7:0]);
		bus(1, IDX_COUNT_LO, 8'hfe);
		tick(v + 1);
		idle(3);
		check(16'(pin_out[2]), 0, "pwm low");
		tick(1);
		idle(3);
		check(16'(pin_out[2]), 1, "pwm high");
		$display("test pwm done");
		// External count pin: one falling edge wraps the counter and raises the overflow request.
		bus(1, IDX_COUNTER_MODE, 8'h07);
		bus(1, IDX_IRQ_MASK, 8'h80);
		bus(1, IDX_COUNT_LO, 8'hff);
		bus(1, IDX_COUNT_HI, 8'hff);
		bus(1, IDX_COUNTER_CONTROL, 8'hc0);
		check(16'(irq_out), 0, "overflow irq idle");
		ext[0] <= 1'b0;
		idle(6);
		ext[0] <= 1'b1;
		idle(6);
		bus(0, IDX_COUNT_LO, 0);
		check(rd, 0, "external count");
		bus(0, IDX_COUNTER_CONTROL, 0);
		check(16'(rd[7]), 1, "overflow flag");
		check(16'(irq_out), 1, "overflow irq");
		$display("test external done");
		// With every module off, all pins are plain ports.
		bus(1, IDX_COUNTER_MODE, 0);
		for (int i = 0; i < NUM_MODULES; i++) bus(1, IDX_MODULE_MODE_BASE + 8'(i), 0);
		v = 16'($urandom);
		m = 8'($urandom);
		ext <= v[13:8];
		bus(1, IDX_PORT_OUT, v[7:0]);
		bus(1, IDX_PORT_DIR, m);
		idle(4);
		check(pin_oe_n_out ^ m[5:0], 16'h3f, "pin direction");
		bus(0, IDX_PIN_READ, 0);
		check(rd, (m[5:0] & v[5:0]) | (~m[5:0] & v[13:8]), "pin read");
		$display("test pins done");
		summarize();
	end
endmodule : tb_top
bind counter_array_capture_compare counter_array_monitor counter_array_monitor_inst (.*);
